// File: bpg_defines.svh
`ifndef BPG_DEFINES_SVH
`define BPG_DEFINES_SVH
// ==========================================
// register offsets
`define BPG_ADDR_PERIOD 4'h0
`define BPG_ADDR_DUTYW 4'h1
`define BPG_ADDR_CTRL 4'h2
`define BPG_ADDR_DUTYB 4'h3
`define BPG_ADDR_DBAND 4'h4
`define BPG_ADDR_TCTRL 4'h5
`define BPG_ADDR_COUNT 4'h6
`define BPG_ADDR_STAT 4'h7
`define BPG_ADDR_DIR 4'h8
// ==========================================
// reset values and fields
`define BPG_PERIOD_RST 8'hff
`define BPG_TICK_DIV 2'h3
`define BPG_PWM_MODE 2'h3
`define BPG_DB_BITS 7
`endif

// File: bpg_pkg.sv
package bpg_pkg;
   typedef enum logic [1:0] {
      BPG_SINGLE = 2'h0,
      BPG_FWD = 2'h1,
      BPG_HALF = 2'h2,
      BPG_REV = 2'h3
   } bpg_mode_type;
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } bpg_pins_type;
   typedef enum logic [2:0] {
      BPG_IDLE = 3'b001,
      BPG_ARM = 3'b010,
      BPG_RUN = 3'b100
   } bpg_state_type;
endpackage : bpg_pkg

// File: bpg_switch_model.sv
`timescale 1ns/1ps
// ==========================================
// external switch drivers, pull-down on every line
module bpg_switch_model (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // pins from the block
   input wire bpg_pkg::bpg_pins_type pin_out,
   input wire bpg_pkg::bpg_pins_type pin_oe,
   // observed lines
   output bpg_pkg::bpg_pins_type wire_lvl,
   output int shoot_cnt
);
   // a released line falls to its pull-down
   assign wire_lvl = pin_out & pin_oe;
   // both switches of one leg on at once
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shoot_cnt <= 0;
      end else if ((wire_lvl.a && wire_lvl.b) || (wire_lvl.c && wire_lvl.d)) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule : bpg_switch_model

// File: bpg_top.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "bpg_defines.svh"
module bpg_top (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // power control
   input wire logic sleep,
   // pins
   output bpg_pkg::bpg_pins_type pin_out,
   output bpg_pkg::bpg_pins_type pin_oe
);
   // ==========================================
   // registers
   logic [7:0] period_register_r;
   logic [7:0] duty_write_register_r;
   logic [7:0] module_control_r;
   logic [7:0] duty_buffer_r;
   logic [1:0] duty_low_latch_r;
   logic [7:0] deadband_control_r;
   logic [7:0] tctrl_r;
   logic [7:0] timer_count_r;
   logic [3:0] pin_direction_r;
   logic timer_match_flag_r;
   logic [3:0] presc_r;
   logic [1:0] tick_cnt_r;
   logic match_pend_r;
   logic pwm_r;
   logic db_a_r;
   logic db_b_r;
   logic [8:0] db_age_r;
   logic [8:0] db_age;
   logic [8:0] db_len;
   logic step;
   logic [9:0] tb_next;
   logic pwm_d_r;
   bpg_pkg::bpg_state_type state_r;
   bpg_pkg::bpg_pins_type pin_out_r;
   logic [7:0] rdata_r;
   logic timer_run;
   logic [1:0] prescale_select;
   logic pwm_on;
   logic ctrl_zero;
   logic tick;
   logic rollover;
   logic [9:0] time_base;
   logic [9:0] duty_act;
   logic [1:0] low_bits;
   bpg_pkg::bpg_mode_type bridge_mode_select;
   logic run;
   assign timer_run = tctrl_r[2];
   assign prescale_select = tctrl_r[1:0];
   assign pwm_on = (module_control_r[3:2] == `BPG_PWM_MODE);
   assign ctrl_zero = (module_control_r == 8'h00);
   assign bridge_mode_select = bpg_pkg::bpg_mode_type'(module_control_r[7:6]);
   assign run = timer_run && !sleep && pwm_on;
   // ==========================================
   // clock divider: four clocks per prescaler count
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= 2'h0;
      end else if (run) begin
         tick_cnt_r <= tick_cnt_r + 2'h1;
      end
   end
   // prescaler 1, 4, 16; postscaler not used
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         presc_r <= 4'h0;
      end else if (run && tick_cnt_r == `BPG_TICK_DIV) begin
         presc_r <= presc_r + 4'h1;
      end
   end
   always_comb begin
      tick = 1'b0;
      low_bits = 2'h0;
      if (run && tick_cnt_r == `BPG_TICK_DIV) begin
         unique case (prescale_select)
            2'h0: tick = 1'b1;
            2'h1: tick = (presc_r[1:0] == 2'h3);
            default: tick = (presc_r == 4'hf);
         endcase
      end
      unique case (prescale_select)
         2'h0: low_bits = tick_cnt_r;
         2'h1: low_bits = presc_r[1:0];
         default: low_bits = presc_r[3:2];
      endcase
   end
   assign time_base = {timer_count_r, low_bits};
   assign duty_act = {duty_buffer_r, duty_low_latch_r};
   assign rollover = tick && match_pend_r;
   assign tb_next = time_base + 10'h001;
   // time base advances at the end of this cycle
   always_comb begin
      step = 1'b0;
      unique case (prescale_select)
         2'h0: step = run;
         2'h1: step = run && (tick_cnt_r == `BPG_TICK_DIV);
         default: step = run && (tick_cnt_r == `BPG_TICK_DIV) && (presc_r[1:0] == 2'h3);
      endcase
   end
   // ==========================================
   // timer and period match
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         timer_count_r <= 8'h00;
         match_pend_r <= 1'b0;
      end else if (reg_wr && reg_addr == `BPG_ADDR_COUNT) begin
         timer_count_r <= reg_wdata;
         match_pend_r <= 1'b0;
      end else if (tick) begin
         if (match_pend_r) begin
            timer_count_r <= 8'h00;
         end else begin
            timer_count_r <= timer_count_r + 8'h01;
         end
         match_pend_r <= 1'b0;
      end else if (run && timer_count_r == period_register_r) begin
         match_pend_r <= 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         timer_match_flag_r <= 1'b0;
      end else if (rollover) begin
         timer_match_flag_r <= 1'b1;
      end else if (reg_wr && reg_addr == `BPG_ADDR_STAT && reg_wdata[0]) begin
         timer_match_flag_r <= 1'b0;
      end
   end
   // duty double buffer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         duty_buffer_r <= 8'h00;
         duty_low_latch_r <= 2'h0;
      end else if (rollover) begin
         duty_buffer_r <= duty_write_register_r;
         duty_low_latch_r <= module_control_r[5:4];
      end else if (reg_wr && reg_addr == `BPG_ADDR_DUTYB && !pwm_on) begin
         duty_buffer_r <= reg_wdata;
      end
   end
   // ==========================================
   // enable sequencing
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= bpg_pkg::BPG_IDLE;
      end else if (!pwm_on) begin
         state_r <= bpg_pkg::BPG_IDLE;
      end else begin
         unique case (state_r)
            bpg_pkg::BPG_IDLE: state_r <= bpg_pkg::BPG_ARM;
            bpg_pkg::BPG_ARM: if (rollover) state_r <= bpg_pkg::BPG_RUN;
            bpg_pkg::BPG_RUN: state_r <= bpg_pkg::BPG_RUN;
            default: state_r <= bpg_pkg::BPG_IDLE;
         endcase
      end
   end
   // pwm waveform
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_r <= 1'b0;
      end else if (state_r != bpg_pkg::BPG_RUN && !(state_r == bpg_pkg::BPG_ARM && rollover)) begin
         pwm_r <= 1'b0;
      end else if (rollover) begin
         pwm_r <= ({duty_write_register_r, module_control_r[5:4]} != 10'h000);
      end else if (step && tb_next == duty_act) begin
         pwm_r <= 1'b0;
      end
   end
   // ==========================================
   // dead band: delay rising edges of both half-bridge phases
   always_comb begin
      db_age = db_age_r;
      if (pwm_r != pwm_d_r) begin
         db_age = 9'h000;
      end
   end
   assign db_len = {deadband_control_r[6:0], 2'h0};
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_d_r <= 1'b0;
         db_age_r <= 9'h000;
         db_a_r <= 1'b0;
         db_b_r <= 1'b0;
      end else if (!sleep) begin
         pwm_d_r <= pwm_r;
         if (db_age == 9'h1ff) begin
            db_age_r <= db_age;
         end else begin
            db_age_r <= db_age + 9'h001;
         end
         db_a_r <= pwm_r && (db_age >= db_len);
         db_b_r <= !pwm_r && (db_age >= db_len);
      end
   end
   // ==========================================
   // output steering and polarity
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out_r <= '0;
      end else if (!sleep) begin
         unique case (bridge_mode_select)
            bpg_pkg::BPG_SINGLE: pin_out_r <= '{pwm_r, 1'b0, 1'b0, 1'b0};
            bpg_pkg::BPG_HALF: pin_out_r <= '{db_a_r, db_b_r, 1'b0, 1'b0};
            bpg_pkg::BPG_FWD: pin_out_r <= '{1'b1, 1'b0, 1'b0, pwm_r};
            bpg_pkg::BPG_REV: pin_out_r <= '{1'b0, pwm_r, 1'b1, 1'b0};
         endcase
      end
   end
   // bits 1 and 0 invert pairs A/C and B/D
   assign pin_out = '{pin_out_r.a ^ module_control_r[1], pin_out_r.b ^ module_control_r[0],
                      pin_out_r.c ^ module_control_r[1], pin_out_r.d ^ module_control_r[0]};
   // drive only pins used by the mode and enabled by direction bits
   always_comb begin
      pin_oe = '0;
      if (!ctrl_zero && pwm_on) begin
         unique case (bridge_mode_select)
            bpg_pkg::BPG_SINGLE: pin_oe = '{~pin_direction_r[3], 1'b0, 1'b0, 1'b0};
            bpg_pkg::BPG_HALF: pin_oe = '{~pin_direction_r[3], ~pin_direction_r[2], 1'b0, 1'b0};
            default: pin_oe = bpg_pkg::bpg_pins_type'(~pin_direction_r);
         endcase
      end
   end
   // ==========================================
   // register writes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         period_register_r <= `BPG_PERIOD_RST;
         duty_write_register_r <= 8'h00;
         module_control_r <= 8'h00;
         deadband_control_r <= 8'h00;
         tctrl_r <= 8'h00;
         pin_direction_r <= 4'hf;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `BPG_ADDR_PERIOD: period_register_r <= reg_wdata;
            `BPG_ADDR_DUTYW: duty_write_register_r <= reg_wdata;
            `BPG_ADDR_CTRL: module_control_r <= reg_wdata;
            `BPG_ADDR_DBAND: deadband_control_r <= reg_wdata;
            `BPG_ADDR_TCTRL: tctrl_r <= {5'h00, reg_wdata[2:0]};
            `BPG_ADDR_DIR: pin_direction_r <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end
   // register reads, one cycle later
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `BPG_ADDR_PERIOD: rdata_r <= period_register_r;
            `BPG_ADDR_DUTYW: rdata_r <= duty_write_register_r;
            `BPG_ADDR_CTRL: rdata_r <= module_control_r;
            `BPG_ADDR_DUTYB: rdata_r <= duty_buffer_r;
            `BPG_ADDR_DBAND: rdata_r <= deadband_control_r;
            `BPG_ADDR_TCTRL: rdata_r <= tctrl_r;
            `BPG_ADDR_COUNT: rdata_r <= timer_count_r;
            `BPG_ADDR_STAT: rdata_r <= {7'h00, timer_match_flag_r};
            `BPG_ADDR_DIR: rdata_r <= {4'h0, pin_direction_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign reg_rdata = rdata_r;
   // ==========================================
   // checks
   a_timer_clear: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover |=> timer_count_r == 8'h00) else $error("timer not cleared");
   a_duty_load: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover |=> duty_buffer_r == $past(duty_write_register_r))
      else $error("duty not loaded");
   a_zero_duty: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover && duty_write_register_r == 8'h00 && module_control_r[5:4] == 2'h0
      |=> !pwm_r) else $error("zero duty went active");
   a_duty_ro: assert property (@(posedge mclk) disable iff (!arst_n)
      pwm_on && !rollover |=> $stable(duty_buffer_r)) else $error("duty buffer written");
   a_sleep_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      sleep && $past(sleep) |-> $stable(timer_count_r) && $stable(pin_out_r))
      else $error("sleep changed state");
   a_fwd_pins: assert property (@(posedge mclk) disable iff (!arst_n)
      bridge_mode_select == bpg_pkg::BPG_FWD && $past(bridge_mode_select) == bpg_pkg::BPG_FWD
      && !sleep |-> pin_out_r.a && !pin_out_r.b && !pin_out_r.c)
      else $error("forward pins wrong");
   a_rev_pins: assert property (@(posedge mclk) disable iff (!arst_n)
      bridge_mode_select == bpg_pkg::BPG_REV && $past(bridge_mode_select) == bpg_pkg::BPG_REV
      && !sleep |-> pin_out_r.c && !pin_out_r.a && !pin_out_r.d)
      else $error("reverse pins wrong");
   a_release_pins: assert property (@(posedge mclk) disable iff (!arst_n)
      ctrl_zero |-> pin_oe == '0) else $error("pins not released");
   a_no_overlap: assert property (@(posedge mclk) disable iff (!arst_n)
      !(db_a_r && db_b_r)) else $error("half bridge overlap");
   a_arm_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      state_r == bpg_pkg::BPG_ARM |-> !pwm_r) else $error("partial pulse");
   // ==========================================
   // sequences for multi-step checks
   sequence s_roll_quiet;
      !rollover [*3];
   endsequence
   sequence s_tick_quiet;
      !tick [*3];
   endsequence
   sequence s_db_hold_a;
      !db_a_r;
   endsequence
   sequence s_db_hold_b;
      !db_b_r;
   endsequence
   a_roll_space: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover |=> s_roll_quiet)
      else $error("period too short");
   a_tick_space: assert property (@(posedge mclk) disable iff (!arst_n)
      tick |=> s_tick_quiet)
      else $error("timer step too fast");
   a_db_rise: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(pwm_r) && deadband_control_r[6:0] != 7'h00 && !sleep && !$past(sleep)
      |=> s_db_hold_a) else $error("dead band skipped on a");
   a_db_fall: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(pwm_r) && deadband_control_r[6:0] != 7'h00 && !sleep && !$past(sleep)
      |=> s_db_hold_b) else $error("dead band skipped on b");
   a_db_follow: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(sleep) && db_a_r |-> $past(pwm_r))
      else $error("phase a active without pwm");
   a_flag_set: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover |=> timer_match_flag_r)
      else $error("match flag not set");
   a_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      timer_match_flag_r && !(reg_wr && reg_addr == `BPG_ADDR_STAT && reg_wdata[0])
      |=> timer_match_flag_r) else $error("match flag lost");
   a_low_load: assert property (@(posedge mclk) disable iff (!arst_n)
      rollover |=> duty_low_latch_r == $past(module_control_r[5:4]))
      else $error("duty low bits not loaded");
   a_timer_step: assert property (@(posedge mclk) disable iff (!arst_n)
      tick && !match_pend_r && !(reg_wr && reg_addr == `BPG_ADDR_COUNT)
      |=> timer_count_r == $past(timer_count_r) + 8'h01) else $error("timer step wrong");
   a_timer_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      !run && !(reg_wr && reg_addr == `BPG_ADDR_COUNT) |=> $stable(timer_count_r))
      else $error("timer moved while stopped");
   a_half_oe: assert property (@(posedge mclk) disable iff (!arst_n)
      bridge_mode_select == bpg_pkg::BPG_HALF |-> !pin_oe.c && !pin_oe.d)
      else $error("half bridge drives c or d");
   a_single_pins: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(bridge_mode_select == bpg_pkg::BPG_SINGLE && !sleep)
      |-> !pin_out_r.b && !pin_out_r.c && !pin_out_r.d) else $error("single mode pins");
   a_half_pins: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(bridge_mode_select == bpg_pkg::BPG_HALF && !sleep)
      |-> pin_out_r.a == $past(db_a_r) && pin_out_r.b == $past(db_b_r))
      else $error("half bridge pins wrong");
   a_arm_wait: assert property (@(posedge mclk) disable iff (!arst_n)
      state_r == bpg_pkg::BPG_ARM && !rollover && pwm_on |=> state_r != bpg_pkg::BPG_RUN)
      else $error("run before period start");
   a_pwm_clear: assert property (@(posedge mclk) disable iff (!arst_n)
      step && tb_next == duty_act && !rollover |=> !pwm_r)
      else $error("pwm not cleared at duty");
endmodule : bpg_top

// File: bridge_pwm_generator_bench.sv
`timescale 1ns/1ps
`include "bpg_defines.svh"
module bridge_pwm_generator_bench;
   logic mclk, arst_n, reg_wr, reg_rd, sleep;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_v, v1;
   bpg_pkg::bpg_pins_type pin_out, pin_oe, wl, po;
   logic [3:0] wv;
   int shoot_cnt, mismatches, cmp_count, cyc, seed, i;
   int tm [12] = '{0, 0, 0, 0, 0, 0, 2, 2, 1, 3, 0, 2};
   int tp [12] = '{9, 7, 3, 3, 5, 5, 15, 15, 9, 9, 9, 15};
   int td [12] = '{-1, -1, -1, -1, 0, 40, 30, 20, 15, -1, -1, 30};
   int ts [12] = '{0, 1, 2, 3, 0, 0, 0, 0, 0, 0, 0, 0};
   int tb [12] = '{0, 0, 0, 0, 0, 0, 3, 8, 0, 0, 0, 2};
   int tq [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3, 3};
   assign wv = wl;
   bpg_top dut_u (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep(sleep),
      .pin_out(pin_out), .pin_oe(pin_oe));
   bpg_switch_model sw_u (.mclk(mclk), .arst_n(arst_n), .pin_out(pin_out), .pin_oe(pin_oe),
      .wire_lvl(wl), .shoot_cnt(shoot_cnt));
   // ==========================================
   // clock and timeout
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         wrap_up;
      end
   end
   // ==========================================
   // bus and compare tasks
   task check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   task wait_flag;
      int n;
      n = 0;
      wr(`BPG_ADDR_STAT, 8'h01);
      rd(`BPG_ADDR_STAT);
      while (rd_v[0] !== 1'b1 && n < 3000) begin
         rd(`BPG_ADDR_STAT);
         n = n + 1;
      end
      check(rd_v[0], 1'b1);
   endtask : wait_flag
   task reset_check(input int n);
      int a;
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (n) @(posedge mclk);
      check(pin_oe, 4'h0);
      check(pin_out, 4'h0);
      arst_n <= 1'b1;
      rd(`BPG_ADDR_PERIOD);
      check(rd_v, `BPG_PERIOD_RST);
      rd(`BPG_ADDR_DIR);
      check(rd_v, 8'h0f);
      rd(`BPG_ADDR_CTRL);
      check(rd_v, 8'h00);
      for (a = 9; a < 16; a++) begin
         rd(a[3:0]);
         check(rd_v, 8'h00);
      end
      $display("reset test done");
   endtask : reset_check
   // ==========================================
   // one configuration, modelled and measured
   task run_case(input int m, input int p, input int du, input int ps, input int db, input int pq);
      int t, w, sc, k, pre;
      int ex [4];
      int got [4];
      logic [3:0] mask;
      pre = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
      t = (p + 1) * 4 * pre;
      w = (du > 4 * (p + 1)) ? t : du * pre;
      ex = '{w, 0, 0, 0};
      mask = 4'h8;
      if (m == 2) begin
         ex = '{(w > 4 * db) ? w - 4 * db : 0, (t - w > 4 * db) ? t - w - 4 * db : 0, 0, 0};
         mask = 4'hc;
      end
      if (m == 1) ex = '{t, 0, 0, w};
      if (m == 3) ex = '{0, w, t, 0};
      if (m != 0) mask = (m == 2) ? 4'hc : 4'hf;
      for (k = 0; k < 4; k++) if (pq[1 - k % 2]) ex[k] = t - ex[k];
      wr(`BPG_ADDR_DIR, 8'h0f);
      wr(`BPG_ADDR_TCTRL, 8'h00);
      wr(`BPG_ADDR_COUNT, 8'h00);
      wr(`BPG_ADDR_PERIOD, p[7:0]);
      wr(`BPG_ADDR_CTRL, {m[1:0], du[1:0], `BPG_PWM_MODE, pq[1:0]});
      wr(`BPG_ADDR_DUTYW, du[9:2]);
      wr(`BPG_ADDR_DBAND, db[7:0]);
      wr(`BPG_ADDR_TCTRL, {5'h00, 1'b1, ps[1:0]});
      wait_flag;
      wr(`BPG_ADDR_DIR, 8'h00);
      wait_flag;
      sc = shoot_cnt;
      got = '{0, 0, 0, 0};
      repeat (2 * t) begin
         @(negedge mclk);
         for (k = 0; k < 4; k++) got[k] = got[k] + wv[3 - k];
      end
      for (k = 0; k < 4; k++) begin
         if (mask[3 - k]) check(got[k], 2 * ex[k]);
      end
      if (pq == 0) check(shoot_cnt - sc, 0);
      check(pin_oe & mask, mask);
      if (m == 2) check(pin_oe & 4'h3, 4'h0);
      rd(`BPG_ADDR_DUTYB);
      check(rd_v, du[9:2]);
      wr(`BPG_ADDR_DUTYB, ~du[9:2]);
      wr(`BPG_ADDR_DUTYW, du[9:2] ^ 8'h01);
      rd(`BPG_ADDR_DUTYB);
      check(rd_v, du[9:2]);
      wait_flag;
      rd(`BPG_ADDR_DUTYB);
      check(rd_v, du[9:2] ^ 8'h01);
      wr(`BPG_ADDR_CTRL, 8'h00);
      @(negedge mclk);
      check(pin_oe, 4'h0);
      $display("case mode %0d period %0d duty %0d done", m, p, du);
   endtask : run_case
   task sleep_test;
      wr(`BPG_ADDR_CTRL, {4'h0, `BPG_PWM_MODE, 2'h0});
      wait_flag;
      @(posedge mclk);
      sleep <= 1'b1;
      rd(`BPG_ADDR_COUNT);
      v1 = rd_v;
      po = pin_out;
      repeat (150) @(posedge mclk);
      rd(`BPG_ADDR_COUNT);
      check(rd_v, v1);
      check(pin_out, po);
      @(posedge mclk);
      sleep <= 1'b0;
      wait_flag;
      wr(`BPG_ADDR_CTRL, 8'h00);
      $display("sleep test done");
   endtask : sleep_test
   task wrap_up;
      $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   // ==========================================
   // main sequence
   initial begin
      seed = 14;
      cyc = 0;
      mismatches = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      sleep = 1'b0;
      reset_check(10);
      for (i = 0; i < 12; i++) begin
         if (td[i] < 0) td[i] = 1 + ($unsigned($random(seed)) % (4 * tp[i] + 3));
         run_case(tm[i], tp[i], td[i], ts[i], tb[i], tq[i]);
         if (i == 2) sleep_test;
      end
      reset_check(3);
      wrap_up;
   end
endmodule : bridge_pwm_generator_bench
